// *** bgc_pkg.sv ***
// Purpose: constants for the battery gauge counter register bank
// Assumes: 100 MHz system clock, 7-bit register address from the serial link decoder
// Notes: counters are 16 bits, registers are 8 bits wide
package bgc_pkg;
  localparam logic [6:0] A_FLASH_COMMAND = 7'h62;
  localparam logic [6:0] A_CLR = 7'h63;
  localparam logic [6:0] A_MODE = 7'h64;
  localparam logic [6:0] A_CHARGE_TIME_COUNT_LOW = 7'h65;
  localparam logic [6:0] A_CHARGE_TIME_COUNT_HIGH = 7'h66;
  localparam logic [6:0] A_DISCHARGE_TIME_COUNT_LOW = 7'h67;
  localparam logic [6:0] A_DISCHARGE_TIME_COUNT_HIGH = 7'h68;
  localparam logic [6:0] A_SDCL = 7'h69;
  localparam logic [6:0] A_SDCH = 7'h6A;
  localparam logic [6:0] A_CCL = 7'h6B;
  localparam logic [6:0] A_CCH = 7'h6C;
  localparam logic [6:0] A_DCL = 7'h6D;
  localparam logic [6:0] A_DCH = 7'h6E;
  localparam logic [6:0] A_FPD = 7'h6F;
  localparam logic [6:0] A_FPA = 7'h70;
  localparam logic [6:0] A_OFFL = 7'h75;
  localparam logic [6:0] A_OFFM = 7'h76;
  localparam logic [6:0] A_CAL = 7'h77;
  localparam logic [6:0] A_ID = 7'h78;
  localparam int unsigned FLASH_DEPTH = 96;
  localparam logic [6:0] FLASH_LAST = 7'h5F;
  localparam logic [7:0] FLASH_ERASED = 8'hFF;
  // field positions
  localparam int CAL_EN_BIT = 7;
  localparam int CAL_REQ_BIT = 6;
  localparam int CAL_OK_BIT = 5;
  localparam int CAL_POL_BIT = 4;
  localparam int MODE_SHORT_BIT = 7;
  localparam int MODE_REGOFF_BIT = 6;
  localparam int MODE_STC_BIT = 5;
  localparam int MODE_STD_BIT = 4;
  localparam int MODE_WT_LSB = 1;
  localparam int CLR_CTC = 4;
  localparam int CLR_DTC = 3;
  localparam int CLR_SDC = 2;
  localparam int CLR_CC = 1;
  localparam int CLR_DC = 0;
  // reset values and command codes
  localparam logic [2:0] WT_RST = 3'h7;
  localparam logic CAL_OK_RST = 1'b1;
  localparam logic [7:0] CMD_NONE = 8'h00;
  localparam logic [7:0] CMD_PROG = 8'h0F;
  localparam logic [7:0] CMD_SLEEP = 8'hF6;
  // timing
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned OFFS_LSB_US = 9760;
  localparam int unsigned OFFS_LSB_CYC = OFFS_LSB_US * CLK_MHZ;
  localparam int unsigned TIME_TICK_US = 878906;
  localparam int unsigned TIME_TICK_CYC = TIME_TICK_US * CLK_MHZ;
  localparam logic [7:0] SLOW_PHASE = 8'h00;
  localparam logic [14:0] SDC_MASK_MAX = 15'h7FFF;
  typedef enum logic [1:0] {PWR_RUN, PWR_WAIT, PWR_SLEEP} bgc_pwr_t;
endpackage

// *** bgc_regs.sv ***
// Purpose: counter and control register bank of a single-cell battery monitor
// Assumes: link decoder gives byte accesses; analog comparators are asynchronous
// Notes: flash page erase, ram transfer and temperature registers are outside
`timescale 1ns/1ps
module bgc_regs #(
  parameter int unsigned OFFS_LSB_CYC = bgc_pkg::OFFS_LSB_CYC,
  parameter int unsigned TIME_TICK_CYC = bgc_pkg::TIME_TICK_CYC,
  // arbitrary id value
  parameter logic [63:0] ID_VALUE = 64'h0123_4567_89AB_CDEF
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // register access from the link decoder
  input wire logic [6:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // analog front end and data line, asynchronous
  input wire logic vfc_chg_i,
  input wire logic vfc_dis_i,
  input wire logic sense_above_i,
  input wire logic sense_below_i,
  input wire logic below_wake_i,
  input wire logic dq_line_i,
  // temperature band 0 (<0C) .. 7 (>60C), same clock
  input wire logic [2:0] temp_band_i,
  // controls to analog and power
  output logic sense_short_o,
  output logic regulator_disable_o,
  output logic [2:0] wake_threshold_o,
  output logic sleep_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  function automatic logic [16:0] add16(input logic [15:0] v, input logic [1:0] n);
    add16 = {1'b0, v} + {15'h0000, n};
  endfunction

  logic [5:0] sync1_r, sync2_r, sync3_r;
  logic vfc_chg_e, vfc_dis_e, above_s, below_s, wake_s, dq_edge;
  logic [7:0] cmd_r, fpa_r, fpd_r, rd_val;
  logic [7:0] flash_mem [bgc_pkg::FLASH_DEPTH];
  logic cal_en_r, cal_req_r, cal_ok_r, cal_pol_r;
  logic [19:0] offs_r, comp_cnt_r;
  logic short_r, regoff_r, stc_r, std_r;
  logic [2:0] wt_r;
  logic [4:0] clr_r;
  logic [15:0] dc_r, cc_r, sdc_r, dtc_r, ctc_r;
  logic [31:0] time_cnt_r, offs_cnt_r;
  logic [14:0] sd_cnt_r;
  logic time_tick, offs_tick, comp_active, comp_fire, slow_ok, sd_fire;
  logic dtc_inc, ctc_inc, wake_ok, cal_done;
  logic [1:0] dis_step, chg_step;
  logic [16:0] dc_sum, cc_sum, dtc_sum, ctc_sum;
  bgc_pkg::bgc_pwr_t pwr_r;

  wire wr_hit = reg_we_i;
  wire [6:0] wa = reg_addr_i;

  // two-stage synchronisers; the third stage only serves edge detection
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync1_r <= 6'h00;
      sync2_r <= 6'h00;
      sync3_r <= 6'h00;
    end else begin
      sync1_r <= {dq_line_i, below_wake_i, sense_below_i, sense_above_i, vfc_dis_i, vfc_chg_i};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // with the sense input shorted the front end sees zero current
  assign vfc_chg_e = sync2_r[0] & ~sync3_r[0] & ~short_r;
  assign vfc_dis_e = sync2_r[1] & ~sync3_r[1] & ~short_r;
  assign above_s = sync2_r[2] & ~short_r;
  assign below_s = sync2_r[3] & ~short_r;
  assign wake_s = sync2_r[4];
  assign dq_edge = sync2_r[5] ^ sync3_r[5];

  // timebases: 1/4096 hour tick and 9.76 ms offset tick
  assign time_tick = (time_cnt_r == TIME_TICK_CYC - 1);
  assign offs_tick = (offs_cnt_r == OFFS_LSB_CYC - 1);
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      time_cnt_r <= 32'h0000_0000;
      offs_cnt_r <= 32'h0000_0000;
      sd_cnt_r <= 15'h0000;
    end else begin
      time_cnt_r <= time_tick ? 32'h0000_0000 : time_cnt_r + 32'h0000_0001;
      offs_cnt_r <= offs_tick ? 32'h0000_0000 : offs_cnt_r + 32'h0000_0001;
      if (time_tick) begin
        sd_cnt_r <= sd_cnt_r + 15'h0001;
      end
    end
  end
  // 16 per hour is every 256th tick of the 4096 per hour base
  assign slow_ok = (sd_cnt_r[7:0] == bgc_pkg::SLOW_PHASE);
  // band 3 (20-30C) gives 4096 ticks, each band step doubles or halves it
  assign sd_fire = time_tick && ((sd_cnt_r & (bgc_pkg::SDC_MASK_MAX >> temp_band_i)) == 15'h0000);

  // calibration and offset registers
  assign cal_done = cal_req_r && wake_s;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cal_en_r <= 1'b0;
      cal_req_r <= 1'b0;
      cal_ok_r <= bgc_pkg::CAL_OK_RST;
      cal_pol_r <= 1'b0;
      offs_r <= 20'h00000;
    end else begin
      if (wr_hit && wa == bgc_pkg::A_CAL) begin
        cal_en_r <= reg_wdata_i[bgc_pkg::CAL_EN_BIT];
        cal_pol_r <= reg_wdata_i[bgc_pkg::CAL_POL_BIT];
        offs_r[19:16] <= reg_wdata_i[3:0];
        if (reg_wdata_i[bgc_pkg::CAL_REQ_BIT]) begin
          cal_req_r <= 1'b1;
          cal_ok_r <= 1'b1;
        end else if (cal_done) begin
          cal_req_r <= 1'b0;
          cal_ok_r <= 1'b0;
        end
      end else if (cal_done) begin
        cal_req_r <= 1'b0;
        cal_ok_r <= 1'b0;
      end
      if (wr_hit && wa == bgc_pkg::A_OFFM) begin
        offs_r[15:8] <= reg_wdata_i;
      end
      if (wr_hit && wa == bgc_pkg::A_OFFL) begin
        offs_r[7:0] <= reg_wdata_i;
      end
    end
  end

  a_cal_finish: assert property (cal_req_r && wake_s && !(wr_hit && wa == bgc_pkg::A_CAL)
    |=> !cal_req_r && !cal_ok_r) else $error("calibration did not complete");

  // compensation: one count per offset interval into the selected counter
  assign comp_active = cal_en_r && !cal_ok_r && offs_r != 20'h00000;
  assign comp_fire = comp_active && offs_tick && (comp_cnt_r + 20'h00001 == offs_r);
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      comp_cnt_r <= 20'h00000;
    end else if (!comp_active || comp_fire) begin
      comp_cnt_r <= 20'h00000;
    end else if (offs_tick) begin
      comp_cnt_r <= comp_cnt_r + 20'h00001;
    end
  end

  // checked at the charge counter, so a stray fire path into it from anywhere is caught
  a_comp_gate: assert property ((!cal_en_r || cal_ok_r) && !vfc_chg_e && !clr_r[bgc_pkg::CLR_CC]
    |=> cc_r == $past(cc_r)) else $error("compensation outside enable window");

  // converter counting of charge and discharge stops while asleep; compensation counts still add
  assign dis_step = {1'b0, vfc_dis_e && pwr_r != bgc_pkg::PWR_SLEEP} + {1'b0, comp_fire && cal_pol_r};
  assign chg_step = {1'b0, vfc_chg_e && pwr_r != bgc_pkg::PWR_SLEEP} + {1'b0, comp_fire && !cal_pol_r};
  assign dc_sum = add16(dc_r, dis_step);
  assign cc_sum = add16(cc_r, chg_step);
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dc_r <= 16'h0000;
    end else if (clr_r[bgc_pkg::CLR_DC]) begin
      dc_r <= 16'h0000;
    end else begin
      dc_r <= dc_sum[15:0];
    end
  end
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cc_r <= 16'h0000;
    end else if (clr_r[bgc_pkg::CLR_CC]) begin
      cc_r <= 16'h0000;
    end else begin
      cc_r <= cc_sum[15:0];
    end
  end

  a_comp_dis: assert property (comp_fire && cal_pol_r && !vfc_dis_e && !clr_r[bgc_pkg::CLR_DC]
    |=> dc_r == $past(dc_r) + 16'h0001) else $error("discharge compensation missed");
  a_dc_wrap: assert property (dc_r == 16'hFFFF && dis_step == 2'h1 && !clr_r[bgc_pkg::CLR_DC]
    |=> dc_r == 16'h0000) else $error("discharge counter did not wrap");

  // self-discharge keeps running in sleep
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sdc_r <= 16'h0000;
    end else if (clr_r[bgc_pkg::CLR_SDC]) begin
      sdc_r <= 16'h0000;
    end else if (sd_fire) begin
      sdc_r <= sdc_r + 16'h0001;
    end
  end

  // time counters; each rollover toggles the slow flag, which picks the rate
  assign dtc_inc = time_tick && below_s && pwr_r != bgc_pkg::PWR_SLEEP && (!std_r || slow_ok);
  assign ctc_inc = time_tick && above_s && pwr_r != bgc_pkg::PWR_SLEEP && (!stc_r || slow_ok);
  assign dtc_sum = add16(dtc_r, 2'h1);
  assign ctc_sum = add16(ctc_r, 2'h1);
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dtc_r <= 16'h0000;
      std_r <= 1'b0;
    end else if (clr_r[bgc_pkg::CLR_DTC]) begin
      dtc_r <= 16'h0000;
      std_r <= 1'b0;
    end else if (dtc_inc) begin
      dtc_r <= dtc_sum[15:0];
      if (dtc_sum[16]) begin
        std_r <= ~std_r;
      end
    end
  end
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctc_r <= 16'h0000;
      stc_r <= 1'b0;
    end else if (clr_r[bgc_pkg::CLR_CTC]) begin
      ctc_r <= 16'h0000;
      stc_r <= 1'b0;
    end else if (ctc_inc) begin
      ctc_r <= ctc_sum[15:0];
      if (ctc_sum[16]) begin
        stc_r <= ~stc_r;
      end
    end
  end

  sequence s_dtc_roll;
    dtc_r == 16'hFFFF && dtc_inc && !clr_r[bgc_pkg::CLR_DTC];
  endsequence
  sequence s_ctc_roll;
    ctc_r == 16'hFFFF && ctc_inc && !clr_r[bgc_pkg::CLR_CTC];
  endsequence
  a_dtc_flag: assert property (s_dtc_roll |=> std_r != $past(std_r) && dtc_r == 16'h0000)
    else $error("discharge time rollover flag wrong");
  a_ctc_flag: assert property (s_ctc_roll |=> stc_r != $past(stc_r) && ctc_r == 16'h0000)
    else $error("charge time rollover flag wrong");

  // clear bits live one cycle: the counters clear, the bit drops by itself
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      clr_r <= 5'h00;
    end else if (wr_hit && wa == bgc_pkg::A_CLR) begin
      clr_r <= reg_wdata_i[4:0];
    end else begin
      clr_r <= 5'h00;
    end
  end

  a_clr_dc: assert property (clr_r[bgc_pkg::CLR_DC] && !(wr_hit && wa == bgc_pkg::A_CLR)
    |=> dc_r == 16'h0000 && !clr_r[bgc_pkg::CLR_DC]) else $error("discharge clear failed");

  // mode register; flags are hardware-owned and bit 0 always holds 0
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      short_r <= 1'b0;
      regoff_r <= 1'b0;
      wt_r <= bgc_pkg::WT_RST;
    end else if (wr_hit && wa == bgc_pkg::A_MODE) begin
      short_r <= reg_wdata_i[bgc_pkg::MODE_SHORT_BIT];
      regoff_r <= reg_wdata_i[bgc_pkg::MODE_REGOFF_BIT];
      wt_r <= reg_wdata_i[bgc_pkg::MODE_WT_LSB +: 3];
    end
  end
  assign sense_short_o = short_r;
  assign regulator_disable_o = regoff_r;
  assign wake_threshold_o = wt_r;

  // flash program address and data
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fpa_r <= 8'h00;
      fpd_r <= 8'h00;
    end else begin
      if (wr_hit && wa == bgc_pkg::A_FPA) begin
        fpa_r <= reg_wdata_i;
      end
      if (wr_hit && wa == bgc_pkg::A_FPD) begin
        fpd_r <= reg_wdata_i;
      end
    end
  end

  // command register; a host write in the finishing cycle wins
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cmd_r <= bgc_pkg::CMD_NONE;
    end else if (wr_hit && wa == bgc_pkg::A_FLASH_COMMAND) begin
      cmd_r <= reg_wdata_i;
    end else if (cmd_r == bgc_pkg::CMD_SLEEP && !wake_ok) begin
      cmd_r <= cmd_r;
    end else begin
      cmd_r <= bgc_pkg::CMD_NONE;
    end
  end

  // programming can only pull bits low, as erased flash reads all ones
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < bgc_pkg::FLASH_DEPTH; i++) begin
        flash_mem[i] <= bgc_pkg::FLASH_ERASED;
      end
    end else if (cmd_r == bgc_pkg::CMD_PROG && fpa_r[6:0] <= bgc_pkg::FLASH_LAST && !fpa_r[7]) begin
      flash_mem[fpa_r[6:0]] <= flash_mem[fpa_r[6:0]] & fpd_r;
    end
  end

  a_prog_and: assert property (cmd_r == bgc_pkg::CMD_PROG && fpa_r < 8'h60
    |=> flash_mem[$past(fpa_r[6:0])] == ($past(flash_mem[fpa_r[6:0]]) & $past(fpd_r)) && cmd_r != bgc_pkg::CMD_PROG
      || $past(wr_hit)) else $error("byte program result wrong");

  // power state: sleep once the threshold condition holds, wake on any line edge
  assign wake_ok = (wt_r == 3'h0) || wake_s;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pwr_r <= bgc_pkg::PWR_RUN;
    end else begin
      case (pwr_r)
        bgc_pkg::PWR_RUN: begin
          if (cmd_r == bgc_pkg::CMD_SLEEP) begin
            pwr_r <= bgc_pkg::PWR_WAIT;
          end
        end
        bgc_pkg::PWR_WAIT: begin
          if (dq_edge) begin
            pwr_r <= bgc_pkg::PWR_RUN;
          end else if (wake_ok) begin
            pwr_r <= bgc_pkg::PWR_SLEEP;
          end
        end
        bgc_pkg::PWR_SLEEP: begin
          if (dq_edge) begin
            pwr_r <= bgc_pkg::PWR_RUN;
          end
        end
        default: pwr_r <= bgc_pkg::PWR_RUN;
      endcase
    end
  end
  assign sleep_o = (pwr_r == bgc_pkg::PWR_SLEEP);

  a_sleep_wake: assert property (sleep_o && dq_edge |=> !sleep_o)
    else $error("no wake on data line edge");
  a_sleep_gate: assert property (!sleep_o ##1 sleep_o |-> $past(wake_ok))
    else $error("sleep entered without wake condition");

  // read mux; unmapped and reserved locations read zero
  always_comb begin
    rd_val = 8'h00;
    if (reg_addr_i <= bgc_pkg::FLASH_LAST) begin
      rd_val = flash_mem[reg_addr_i];
    end else if (reg_addr_i >= bgc_pkg::A_ID) begin
      rd_val = ID_VALUE[{reg_addr_i[2:0], 3'h0} +: 8];
    end else begin
      case (reg_addr_i)
        bgc_pkg::A_FLASH_COMMAND: rd_val = cmd_r;
        bgc_pkg::A_CLR: rd_val = {3'h0, clr_r};
        bgc_pkg::A_MODE: rd_val = {short_r, regoff_r, stc_r, std_r, wt_r, 1'b0};
        bgc_pkg::A_CHARGE_TIME_COUNT_LOW: rd_val = ctc_r[7:0];
        bgc_pkg::A_CHARGE_TIME_COUNT_HIGH: rd_val = ctc_r[15:8];
        bgc_pkg::A_DISCHARGE_TIME_COUNT_LOW: rd_val = dtc_r[7:0];
        bgc_pkg::A_DISCHARGE_TIME_COUNT_HIGH: rd_val = dtc_r[15:8];
        bgc_pkg::A_SDCL: rd_val = sdc_r[7:0];
        bgc_pkg::A_SDCH: rd_val = sdc_r[15:8];
        bgc_pkg::A_CCL: rd_val = cc_r[7:0];
        bgc_pkg::A_CCH: rd_val = cc_r[15:8];
        bgc_pkg::A_DCL: rd_val = dc_r[7:0];
        bgc_pkg::A_DCH: rd_val = dc_r[15:8];
        bgc_pkg::A_FPD: rd_val = fpd_r;
        bgc_pkg::A_FPA: rd_val = fpa_r;
        bgc_pkg::A_OFFL: rd_val = offs_r[7:0];
        bgc_pkg::A_OFFM: rd_val = offs_r[15:8];
        bgc_pkg::A_CAL: rd_val = {cal_en_r, cal_req_r, cal_ok_r, cal_pol_r, offs_r[19:16]};
        default: rd_val = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_re_i;
      if (reg_re_i) begin
        reg_rdata_o <= rd_val;
      end
    end
  end

  a_id_read: assert property (reg_re_i && reg_addr_i == bgc_pkg::A_ID
    |=> reg_rvalid_o && reg_rdata_o == ID_VALUE[7:0]) else $error("id byte read wrong");
endmodule

// *** bgc_host.sv ***
// Purpose: host side of the register link, byte reads and writes
// Assumes: inputs of the bank are driven at the falling clock edge
// Notes: idle address lines show the inverse of the last address; write data is inverted after a write but keeps its value after a read
`timescale 1ns/1ps
module bgc_host (
  // clock
  input wire logic sys_clk_i,
  // register bus toward the bank
  output logic [6:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_we_o,
  output logic reg_re_o,
  input wire logic [7:0] reg_rdata_i,
  input wire logic reg_rvalid_i
);
  initial begin
    reg_addr_o = 7'h00;
    reg_wdata_o = 8'h00;
    reg_we_o = 1'b0;
    reg_re_o = 1'b0;
  end

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    reg_addr_o = a;
    reg_wdata_o = (a == bgc_pkg::A_MODE) ? {d[7:1], 1'b0} : d;
    reg_we_o = 1'b1;
    @(negedge sys_clk_i);
    reg_we_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask

  // read data is taken in the cycle after the strobe, while valid stands
  task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic v);
    @(negedge sys_clk_i);
    reg_addr_o = a;
    reg_re_o = 1'b1;
    @(negedge sys_clk_i);
    reg_re_o = 1'b0;
    reg_addr_o = ~a;
    d = reg_rdata_i;
    v = reg_rvalid_i;
  endtask
endmodule

// *** testbench.sv ***
// Purpose: self-checking bench of the counter register bank
// Assumes: shortened tick and offset periods so counts are reached quickly
// Notes: counter checks use ranges where tick phase is not pinned down
`timescale 1ns/1ps
module testbench;
  localparam logic [63:0] ID = 64'h0123_4567_89AB_CDEF;
  logic sys_clk_i, rstn_i, reg_we, reg_re, rvalid;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, rdata, rv, keep;
  logic vv, vfc_chg, vfc_dis, s_above, s_below, b_wake, dq;
  logic [2:0] band, wt;
  logic short_o, regoff_o, sleep_o;
  int bad_count, num_checks;

  bgc_host u_host (.sys_clk_i(sys_clk_i), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata),
    .reg_we_o(reg_we), .reg_re_o(reg_re), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid));

  bgc_regs #(.OFFS_LSB_CYC(8), .TIME_TICK_CYC(20), .ID_VALUE(ID)) u_dut (.sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_we_i(reg_we),
    .reg_re_i(reg_re), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .vfc_chg_i(vfc_chg),
    .vfc_dis_i(vfc_dis), .sense_above_i(s_above), .sense_below_i(s_below), .below_wake_i(b_wake),
    .dq_line_i(dq), .temp_band_i(band), .sense_short_o(short_o), .regulator_disable_o(regoff_o),
    .wake_threshold_o(wt), .sleep_o(sleep_o));

  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task chk_rng(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
    num_checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  task rdc(input logic [6:0] a, input logic [7:0] exp);
    u_host.rd(a, rv, vv);
    chk({7'h00, vv}, 8'h01);
    chk(rv, exp);
  endtask

  task rdr(input logic [6:0] a, input logic [7:0] lo, input logic [7:0] hi);
    u_host.rd(a, rv, vv);
    chk_rng(rv, lo, hi);
  endtask

  // a converter pulse is held long enough to pass the two-flop synchroniser
  task vpulse(input logic chg, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge sys_clk_i);
      vfc_chg = chg;
      vfc_dis = ~chg;
      repeat (4) @(negedge sys_clk_i);
      vfc_chg = 1'b0;
      vfc_dis = 1'b0;
      repeat (4) @(negedge sys_clk_i);
    end
  endtask

  task wait_sleep(input logic want);
    for (int i = 0; i < 20 && sleep_o !== want; i++) @(negedge sys_clk_i);
    chk({7'h00, sleep_o}, {7'h00, want});
  endtask

  initial begin
    repeat (100000) @(posedge sys_clk_i);
    bad_count++;
    finish_test();
  end

  initial begin
    {rstn_i, vfc_chg, vfc_dis, s_above, s_below, b_wake, dq} = 7'h00;
    band = 3'h0;
    bad_count = 0;
    num_checks = 0;
    repeat (6) @(negedge sys_clk_i);
    rstn_i = 1'b1;
    rdc(bgc_pkg::A_MODE, 8'h0E);
    chk({5'h00, wt}, 8'h07);
    rdc(bgc_pkg::A_CAL, 8'h20);
    rdc(7'h71, 8'h00);
    for (int k = 0; k < 8; k++) rdc(bgc_pkg::A_ID + 7'(k), ID[8*k +: 8]);
    u_host.wr(bgc_pkg::A_ID, 8'h00);
    rdc(bgc_pkg::A_ID, 8'hEF);
    u_host.wr(bgc_pkg::A_MODE, 8'hFF);
    rdc(bgc_pkg::A_MODE, 8'hCE);
    chk({6'h00, short_o, regoff_o}, 8'h03);
    // with the sense input shorted a converter pulse must not count
    vpulse(1'b1, 1);
    rdc(bgc_pkg::A_CCL, 8'h00);
    u_host.wr(bgc_pkg::A_MODE, 8'h0E);
    chk({6'h00, short_o, regoff_o}, 8'h00);
    vpulse(1'b1, 3);
    vpulse(1'b0, 2);
    rdc(bgc_pkg::A_CCL, 8'h03);
    rdc(bgc_pkg::A_DCL, 8'h02);
    u_host.wr(bgc_pkg::A_CLR, 8'h03);
    rdc(bgc_pkg::A_CLR, 8'h00);
    rdc(bgc_pkg::A_CCL, 8'h00);
    rdc(bgc_pkg::A_DCL, 8'h00);
    // time counters, 20 cycles per tick
    u_host.wr(bgc_pkg::A_CLR, 8'h18);
    s_above = 1'b1;
    repeat (400) @(negedge sys_clk_i);
    s_above = 1'b0;
    rdr(bgc_pkg::A_CHARGE_TIME_COUNT_LOW, 8'd18, 8'd21);
    rdc(bgc_pkg::A_DISCHARGE_TIME_COUNT_LOW, 8'h00);
    s_below = 1'b1;
    repeat (400) @(negedge sys_clk_i);
    s_below = 1'b0;
    rdr(bgc_pkg::A_DISCHARGE_TIME_COUNT_LOW, 8'd18, 8'd21);
    rdc(bgc_pkg::A_MODE, 8'h0E);
    // hottest band: one count every 256 ticks
    u_host.wr(bgc_pkg::A_CLR, 8'h04);
    band = 3'h7;
    repeat (5200) @(negedge sys_clk_i);
    band = 3'h0;
    rdr(bgc_pkg::A_SDCL, 8'd1, 8'd2);
    rdc(bgc_pkg::A_SDCH, 8'h00);
    // byte program ands the data into the erased byte, twice
    u_host.wr(bgc_pkg::A_FPA, 8'h10);
    u_host.wr(bgc_pkg::A_FPD, 8'hA5);
    u_host.wr(bgc_pkg::A_FLASH_COMMAND, bgc_pkg::CMD_PROG);
    repeat (2) @(negedge sys_clk_i);
    rdc(7'h10, 8'hA5);
    rdc(bgc_pkg::A_FLASH_COMMAND, 8'h00);
    u_host.wr(bgc_pkg::A_FPD, 8'h3C);
    u_host.wr(bgc_pkg::A_FLASH_COMMAND, bgc_pkg::CMD_PROG);
    repeat (2) @(negedge sys_clk_i);
    rdc(7'h10, 8'h24);
    // compensation blocked until calibration succeeds
    u_host.wr(bgc_pkg::A_OFFL, 8'h02);
    u_host.wr(bgc_pkg::A_CAL, 8'h80);
    repeat (100) @(negedge sys_clk_i);
    rdc(bgc_pkg::A_CCL, 8'h00);
    u_host.wr(bgc_pkg::A_CAL, 8'hC0);
    rdc(bgc_pkg::A_CAL, 8'hE0);
    b_wake = 1'b1;
    repeat (5) @(negedge sys_clk_i);
    b_wake = 1'b0;
    rdc(bgc_pkg::A_CAL, 8'h80);
    u_host.wr(bgc_pkg::A_CLR, 8'h03);
    repeat (160) @(negedge sys_clk_i);
    rdr(bgc_pkg::A_CCL, 8'd8, 8'd11);
    u_host.wr(bgc_pkg::A_CAL, 8'h90);
    repeat (160) @(negedge sys_clk_i);
    rdr(bgc_pkg::A_DCL, 8'd8, 8'd11);
    u_host.wr(bgc_pkg::A_CAL, 8'h00);
    u_host.rd(bgc_pkg::A_DCL, keep, vv);
    repeat (100) @(negedge sys_clk_i);
    rdc(bgc_pkg::A_DCL, keep);
    // zero threshold sleeps regardless of sense; self-discharge runs on while asleep
    u_host.wr(bgc_pkg::A_CLR, 8'h04);
    u_host.wr(bgc_pkg::A_MODE, 8'h00);
    chk({5'h00, wt}, 8'h00);
    u_host.wr(bgc_pkg::A_FLASH_COMMAND, bgc_pkg::CMD_SLEEP);
    wait_sleep(1'b1);
    band = 3'h7;
    repeat (5200) @(negedge sys_clk_i);
    band = 3'h0;
    rdr(bgc_pkg::A_SDCL, 8'd1, 8'd2);
    chk({7'h00, sleep_o}, 8'h01);
    dq = 1'b1;
    wait_sleep(1'b0);
    rdc(bgc_pkg::A_FLASH_COMMAND, 8'h00);
    finish_test();
  end
endmodule
